// >>> verilog/oarc_pkg.sv
// Constants for the OLED address-window and re-map command decoder.
// Assumes a byte-wide host port with a data/command select beside it.
package oarc_pkg;
	localparam logic [7:0] CMD_COLUMN = 8'h15;
	localparam logic [7:0] CMD_ROW = 8'h75;
	localparam logic [7:0] CMD_RAM_WRITE = 8'h5C;
	localparam logic [7:0] CMD_RAM_READ = 8'h5D;
	localparam logic [7:0] CMD_REMAP = 8'hA0;
	localparam logic [6:0] ADDR_MAX = 7'h7F;
	localparam logic [6:0] COL_START_RESET = 7'h00;
	localparam logic [6:0] COL_END_RESET = 7'h7F;
	localparam logic [6:0] ROW_START_RESET = 7'h00;
	localparam logic [6:0] ROW_END_RESET = 7'h7F;
	localparam logic [7:0] REMAP_RESET = 8'h60;
	localparam int REMAP_INC_BIT = 0;
	localparam int REMAP_COLREV_BIT = 1;
	localparam int REMAP_SWAP_BIT = 2;
	localparam int REMAP_RSVD_BIT = 3;
	localparam int REMAP_SCANREV_BIT = 4;
	localparam int REMAP_SPLIT_BIT = 5;
	localparam int REMAP_DEPTH_LSB = 6;
	// Avalon register byte addresses
	localparam logic [3:0] REG_COLUMN = 4'h0;
	localparam logic [3:0] REG_ROW = 4'h4;
	localparam logic [3:0] REG_REMAP = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hC;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PARAM_A = 3'b001,
		ST_PARAM_B = 3'b010,
		ST_WRITE = 3'b011,
		ST_READ = 3'b100
	} oarc_state_type;
endpackage

// >>> verilog/oarc_fifo.sv
// Synchronous flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module oarc_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);
	// Wrap-bit full test only works for a power-of-two depth
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
	begin
		$error("oarc_fifo depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	logic push;
	logic pop;
	// Full when pointers differ only in the wrap bit
	assign inReady = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData = mem_q[rdPtr_q[AW-1:0]];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	// Storage, no reset needed for the data
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_q[wrPtr_q[AW-1:0]] <= inData;
	end
	// Pointers
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
		end
	end
endmodule

// >>> verilog/oarc_pointer.sv
// Display-RAM address pointer that walks the programmed window.
// Assumes start and end are stable while stepping.
`timescale 1ns/1ns
module oarc_pointer
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic step,
	input wire logic vertical,
	input wire logic [6:0] colStart,
	input wire logic [6:0] colEnd,
	input wire logic [6:0] rowStart,
	input wire logic [6:0] rowEnd,
	output logic [6:0] col_q,
	output logic [6:0] row_q
);
	logic colWrap;
	logic rowWrap;
	assign colWrap = col_q == colEnd;
	assign rowWrap = row_q == rowEnd;
	// Wrap to start and step the other dimension
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			col_q <= 7'h00;
			row_q <= 7'h00;
		end
		else if (load)
		begin
			col_q <= colStart;
			row_q <= rowStart;
		end
		else if (step)
		begin
			if (!vertical) // R15
			begin
				col_q <= colWrap ? colStart : col_q + 7'h01;
				if (colWrap)
					row_q <= rowWrap ? rowStart : row_q + 7'h01;
			end
			else
			begin
				row_q <= rowWrap ? rowStart : row_q + 7'h01;
				if (rowWrap)
					col_q <= colWrap ? colStart : col_q + 7'h01;
			end
		end
	end
endmodule

// >>> verilog/oarc_top.sv
// Command decoder for window, re-map and RAM access commands.
// Assumes host bytes arrive synchronous to sys_clk with a one-cycle strobe.
// How it works
// R1: Host sends commands with select low and parameter bytes with select high.
// R2: 0x15 takes column start then column end, seven bits each.
// R3: Column window resets to 0..127, values 0 to 127.
// R4: 0x75 takes row start then end, reset 0..127.
// R5: 0x5C opens a write phase; data bytes go to RAM at pointer.
// R6: 0x5D opens a read phase; host reads RAM at pointer.
// R7: 0xA0 takes config byte then a zero byte.
// R8: Config bit 0 picks horizontal or vertical increment.
// R9: Config bit 1 reverses column to segment mapping.
// R10: Config bit 2 swaps colour component order.
// R11: Config bit 3 reserved, reset 0.
// R12: Config bit 4 reverses common scan direction.
// R13: Config bit 5 enables odd/even common split, set at reset.
// R14: Config bits 7:6 colour depth, reset 65k.
// R15: Pointer wraps at window end and steps the other dimension.
`timescale 1ns/1ns
module oarc_top
#(
	parameter int FIFO_DEPTH = oarc_pkg::FIFO_DEPTH
)
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] hostByte,
	input wire logic hostDataSel,
	input wire logic hostWrite,
	output logic hostWriteReady_q,
	input wire logic hostRead,
	output logic [7:0] hostReadByte_q,
	output logic hostReadValid_q,
	output logic ramWrite_q,
	output logic [7:0] ramWriteByte_q,
	output logic ramReadReq_q,
	output logic [6:0] ramCol_q,
	output logic [6:0] ramRow_q,
	input wire logic [7:0] ramReadByte,
	output logic segRemap_q,
	output logic colourSwap_q,
	output logic comScanReverse_q,
	output logic comSplit_q,
	output logic [1:0] colourDepth_q,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata_q,
	output logic avs_waitrequest_q
);
	if (FIFO_DEPTH < 2)
	begin
		$error("oarc_top fifo depth too small");
	end
	oarc_pkg::oarc_state_type state_q;
	logic [7:0] cmd_q;
	logic [7:0] paramA_q;
	logic [6:0] colStart_q;
	logic [6:0] colEnd_q;
	logic [6:0] rowStart_q;
	logic [6:0] rowEnd_q;
	logic [7:0] remap_q;
	logic [7:0] fifoData;
	logic fifoValid;
	logic fifoReady;
	logic fifoPop;
	logic fifoInReady;
	logic [7:0] fifoByte;
	logic [7:0] fifoInByte;
	logic fifoInValid;
	logic [6:0] col_q;
	logic [6:0] row_q;
	logic ptrLoad;
	logic ptrStep;
	logic readPend_q;
	logic busWr;
	logic byteTake;
	// Host bytes queue here; command and data bytes alike stall when full
	assign fifoInByte = hostByte;
	assign fifoInValid = hostWrite && hostWriteReady_q;
	oarc_fifo #(.WIDTH(oarc_pkg::FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo
	(
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.inData({fifoInByte[7:1], fifoInByte[0]}),
		.inValid(fifoInValid),
		.inReady(fifoInReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(fifoReady)
	);
	assign fifoByte = fifoData;
	// Select bit rides beside the data in a parallel one-bit FIFO
	logic selOut;
	logic selValid;
	oarc_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_sel
	(
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.inData(hostDataSel),
		.inValid(fifoInValid),
		.inReady(),
		.outData(selOut),
		.outValid(selValid),
		.outReady(fifoReady)
	);
	// Drain pauses only while a read is pending; a command byte must
	// still drain in a read phase, or the host could never leave it
	assign fifoReady = !readPend_q;
	assign fifoPop = fifoValid && selValid && fifoReady;
	assign byteTake = fifoPop;
	// Registered ready trails fullness by a cycle; host must space writes near full
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
			hostWriteReady_q <= 1'b0;
		else
			hostWriteReady_q <= fifoInReady;
	end
	// Window pointer; a load beats a step asked in the same cycle
	oarc_pointer u_ptr
	(
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.load(ptrLoad),
		.step(ptrStep),
		.vertical(remap_q[oarc_pkg::REMAP_INC_BIT]), // R8
		.colStart(colStart_q),
		.colEnd(colEnd_q),
		.rowStart(rowStart_q),
		.rowEnd(rowEnd_q),
		.col_q(col_q),
		.row_q(row_q)
	);
	// A command byte (select low) always restarts decoding
	assign ptrLoad = byteTake && !selOut && (fifoByte == oarc_pkg::CMD_RAM_WRITE ||
		fifoByte == oarc_pkg::CMD_RAM_READ); // R5 R6
	// One step per RAM data byte or per read request taken
	assign ptrStep = (byteTake && selOut && state_q == oarc_pkg::ST_WRITE) ||
		(hostRead && state_q == oarc_pkg::ST_READ && !readPend_q); // R15
	// Command decoder; a parameter byte with no command pending is dropped
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			state_q <= oarc_pkg::ST_IDLE;
			cmd_q <= 8'h00;
			paramA_q <= 8'h00;
		end
		else if (byteTake && !selOut) // R1
		begin
			cmd_q <= fifoByte;
			unique case (fifoByte)
				oarc_pkg::CMD_COLUMN, oarc_pkg::CMD_ROW, oarc_pkg::CMD_REMAP:
					state_q <= oarc_pkg::ST_PARAM_A; // R2 R4 R7
				oarc_pkg::CMD_RAM_WRITE:
					state_q <= oarc_pkg::ST_WRITE; // R5
				oarc_pkg::CMD_RAM_READ:
					state_q <= oarc_pkg::ST_READ; // R6
				default:
					state_q <= oarc_pkg::ST_IDLE;
			endcase
		end
		else if (byteTake)
		begin
			unique case (state_q)
				oarc_pkg::ST_PARAM_A:
				begin
					paramA_q <= fifoByte;
					state_q <= oarc_pkg::ST_PARAM_B;
				end
				oarc_pkg::ST_PARAM_B:
					state_q <= oarc_pkg::ST_IDLE;
				default:
					state_q <= state_q;
			endcase
		end
	end
	// Window and re-map registers, loaded on the second parameter
	// A bus write to the column, row or re-map address in the same cycle wins and the host parameter is lost
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			colStart_q <= oarc_pkg::COL_START_RESET; // R3
			colEnd_q <= oarc_pkg::COL_END_RESET; // R3
			rowStart_q <= oarc_pkg::ROW_START_RESET; // R4
			rowEnd_q <= oarc_pkg::ROW_END_RESET; // R4
			remap_q <= oarc_pkg::REMAP_RESET; // R11 R13 R14
		end
		else if (busWr && avs_address == oarc_pkg::REG_COLUMN)
		begin
			colStart_q <= avs_writedata[6:0];
			colEnd_q <= avs_writedata[14:8];
		end
		else if (busWr && avs_address == oarc_pkg::REG_ROW)
		begin
			rowStart_q <= avs_writedata[6:0];
			rowEnd_q <= avs_writedata[14:8];
		end
		else if (busWr && avs_address == oarc_pkg::REG_REMAP)
			remap_q <= avs_writedata[7:0];
		else if (byteTake && selOut && state_q == oarc_pkg::ST_PARAM_B)
		begin
			unique case (cmd_q)
				oarc_pkg::CMD_COLUMN:
				begin
					colStart_q <= paramA_q[6:0]; // R2
					colEnd_q <= fifoByte[6:0];
				end
				oarc_pkg::CMD_ROW:
				begin
					rowStart_q <= paramA_q[6:0]; // R4
					rowEnd_q <= fifoByte[6:0];
				end
				oarc_pkg::CMD_REMAP:
					remap_q <= paramA_q; // R7 second byte ignored
				default:
					remap_q <= remap_q;
			endcase
		end
	end
	// Mode outputs straight from the config byte
	// Reset values taken from the config reset byte so the two never disagree
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			segRemap_q <= oarc_pkg::REMAP_RESET[oarc_pkg::REMAP_COLREV_BIT]; // R9
			colourSwap_q <= oarc_pkg::REMAP_RESET[oarc_pkg::REMAP_SWAP_BIT]; // R10
			comScanReverse_q <= oarc_pkg::REMAP_RESET[oarc_pkg::REMAP_SCANREV_BIT]; // R12
			comSplit_q <= oarc_pkg::REMAP_RESET[oarc_pkg::REMAP_SPLIT_BIT]; // R13
			colourDepth_q <= oarc_pkg::REMAP_RESET[oarc_pkg::REMAP_DEPTH_LSB+1:oarc_pkg::REMAP_DEPTH_LSB]; // R14
		end
		else
		begin
			segRemap_q <= remap_q[oarc_pkg::REMAP_COLREV_BIT]; // R9
			colourSwap_q <= remap_q[oarc_pkg::REMAP_SWAP_BIT]; // R10
			comScanReverse_q <= remap_q[oarc_pkg::REMAP_SCANREV_BIT]; // R12
			comSplit_q <= remap_q[oarc_pkg::REMAP_SPLIT_BIT]; // R13
			colourDepth_q <= remap_q[oarc_pkg::REMAP_DEPTH_LSB+1:oarc_pkg::REMAP_DEPTH_LSB]; // R14
		end
	end
	// RAM port; column reversal applied on the segment side, not here
	// Address is the pointer before it steps, so it lines up with the byte
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			ramWrite_q <= 1'b0;
			ramWriteByte_q <= 8'h00;
			ramReadReq_q <= 1'b0;
			ramCol_q <= 7'h00;
			ramRow_q <= 7'h00;
			readPend_q <= 1'b0;
			hostReadValid_q <= 1'b0;
			hostReadByte_q <= 8'h00;
		end
		else
		begin
			ramWrite_q <= byteTake && selOut && state_q == oarc_pkg::ST_WRITE; // R5
			ramWriteByte_q <= fifoByte;
			ramCol_q <= col_q; // R8
			ramRow_q <= row_q;
			ramReadReq_q <= hostRead && state_q == oarc_pkg::ST_READ && !readPend_q; // R6
			if (hostRead && state_q == oarc_pkg::ST_READ && !readPend_q)
				readPend_q <= 1'b1;
			else if (ramReadReq_q)
				readPend_q <= 1'b0;
			hostReadValid_q <= ramReadReq_q;
			if (ramReadReq_q)
				hostReadByte_q <= ramReadByte;
		end
	end
	// Avalon slave: one wait cycle, then answer
	// Read data follows the address every cycle; valid as waitrequest drops
	assign busWr = avs_write && !avs_waitrequest_q;
	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			avs_waitrequest_q <= 1'b1;
			avs_readdata_q <= 32'h00000000;
		end
		else
		begin
			avs_waitrequest_q <= !((avs_read || avs_write) && avs_waitrequest_q);
			unique case (avs_address)
				oarc_pkg::REG_COLUMN:
					avs_readdata_q <= {17'h00000, colEnd_q, 1'b0, colStart_q};
				oarc_pkg::REG_ROW:
					avs_readdata_q <= {17'h00000, rowEnd_q, 1'b0, rowStart_q};
				oarc_pkg::REG_REMAP:
					avs_readdata_q <= {24'h000000, remap_q};
				oarc_pkg::REG_STATUS:
					avs_readdata_q <= {5'h00, state_q, 1'b0, row_q, 1'b0, col_q, 7'h00, fifoValid};
				default:
					avs_readdata_q <= 32'h00000000;
			endcase
		end
	end
endmodule

// >>> sim/oarc_checker.sv
// Port-level checks for oarc_top.
// Bound to every oarc_top instance; one clock domain.
`timescale 1ns/1ns
module oarc_checker
(
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic hostWriteReady_q,
	input wire logic [7:0] hostReadByte_q,
	input wire logic hostReadValid_q,
	input wire logic ramWrite_q,
	input wire logic ramReadReq_q,
	input wire logic [7:0] ramReadByte,
	input wire logic segRemap_q,
	input wire logic comSplit_q,
	input wire logic [1:0] colourDepth_q,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	reset_defaults_a: assert property ($past(!rst_b) |-> comSplit_q && colourDepth_q == 2'h1 && !segRemap_q)
		else $error("reset defaults wrong");
	ready_after_reset_a: assert property ($rose(rst_b) |=> hostWriteReady_q)
		else $error("host port not ready after reset");
	ram_exclusive_a: assert property (!(ramWrite_q && ramReadReq_q))
		else $error("ram write and read together");
	read_answer_a: assert property (ramReadReq_q |=> hostReadValid_q && hostReadByte_q == $past(ramReadByte))
		else $error("read byte not returned");
	read_cause_a: assert property (hostReadValid_q |-> $past(ramReadReq_q))
		else $error("read byte without ram request");
	read_pulse_a: assert property (hostReadValid_q |=> !hostReadValid_q)
		else $error("read valid longer than a cycle");
	bus_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest_q |=> !avs_waitrequest_q)
		else $error("bus wait state count wrong");
	bus_idle_a: assert property (!avs_read && !avs_write |-> avs_waitrequest_q)
		else $error("waitrequest low while idle");
	// Main scenarios reached
	cover property (ramWrite_q);
	cover property (hostReadValid_q);
	cover property (avs_write && !avs_waitrequest_q);
endmodule

bind oarc_top oarc_checker i_chk(.sys_clk, .rst_b, .hostWriteReady_q, .hostReadByte_q, .hostReadValid_q,
	.ramWrite_q, .ramReadReq_q, .ramReadByte, .segRemap_q, .comSplit_q, .colourDepth_q,
	.avs_read, .avs_write, .avs_waitrequest_q);

// >>> sim/oarc_host_model.sv
// Host controller model: command, parameter and read requests.
// Tasks are called from the bench right after a clock edge.
`timescale 1ns/1ns
module oarc_host_model
(
	input wire logic sys_clk,
	input wire logic hostWriteReady_q,
	output logic [7:0] hostByte,
	output logic hostDataSel,
	output logic hostWrite,
	output logic hostRead
);
	int gap = 0;
	// Quiet port at start
	initial
	begin
		hostByte = 8'h00;
		hostDataSel = 1'b0;
		hostWrite = 1'b0;
		hostRead = 1'b0;
	end
	// Held until ready seen; spaced so a near-full FIFO is never overrun
	task automatic send(input logic sel, input logic [7:0] b);
	begin
		hostDataSel <= sel;
		hostByte <= b;
		hostWrite <= 1'b1;
		@(posedge sys_clk);
		while (!hostWriteReady_q)
			@(posedge sys_clk);
		hostWrite <= 1'b0;
		hostByte <= ~b;
		repeat (1 + gap) @(posedge sys_clk);
	end
	endtask
	// One read pulse, then the spacing a read needs
	task automatic rd();
	begin
		hostRead <= 1'b1;
		@(posedge sys_clk);
		hostRead <= 1'b0;
		repeat (3 + gap) @(posedge sys_clk);
	end
	endtask
endmodule

// >>> sim/oarc_tb_top.sv
// Bench top for oarc_top with host model, bus master and RAM stub.
// Expected results are queued; a monitor checks them in order.
`timescale 1ns/1ns
module oarc_tb_top;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hostDataSel, hostWrite, hostRead, hostWriteReady_q, hostReadValid_q, ramWrite_q, ramReadReq_q;
	logic [7:0] hostByte, hostReadByte_q, ramWriteByte_q, cfg;
	logic [7:0] ramReadByte = 8'h00;
	logic [6:0] ramCol_q, ramRow_q;
	logic [6:0] cs = 7'h02, ce = 7'h04, rs = 7'h05, re = 7'h06;
	logic vert = 1'b0;
	logic segRemap_q, colourSwap_q, comScanReverse_q, comSplit_q;
	logic [1:0] colourDepth_q;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest_q;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata_q;
	logic [31:0] expAddr[$], expWr[$], expRd[$], expAv[$];
	int n_fail = 0, tests_run = 0;
	integer seed = 32'h940D;
	oarc_top i_dut(.sys_clk, .rst_b, .hostByte, .hostDataSel, .hostWrite, .hostWriteReady_q, .hostRead,
		.hostReadByte_q, .hostReadValid_q, .ramWrite_q, .ramWriteByte_q, .ramReadReq_q, .ramCol_q, .ramRow_q,
		.ramReadByte, .segRemap_q, .colourSwap_q, .comScanReverse_q, .comSplit_q, .colourDepth_q,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata_q, .avs_waitrequest_q);
	oarc_host_model i_host(.sys_clk, .hostWriteReady_q, .hostByte, .hostDataSel, .hostWrite, .hostRead);
	// Clock
	initial
		forever #5 sys_clk = ~sys_clk;
	// RAM stub returns a fresh byte each cycle
	always @(posedge sys_clk)
		ramReadByte <= 8'($random(seed));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	begin
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	end
	endtask
	// Oldest note taken as each result shows
	always @(posedge sys_clk)
	begin
		if (ramWrite_q || ramReadReq_q)
			chk("ram address", expAddr.pop_front(), {18'h0, ramRow_q, ramCol_q});
		if (ramWrite_q)
			chk("ram byte", expWr.pop_front(), {24'h0, ramWriteByte_q});
		if (ramReadReq_q)
			expRd.push_back({24'h0, ramReadByte});
		if (hostReadValid_q)
			chk("read byte", expRd.pop_front(), {24'h0, hostReadByte_q});
		if (avs_read && !avs_waitrequest_q)
			chk("bus read", expAv.pop_front(), avs_readdata_q);
	end
	// Bus cycle; for a read d is the expected data
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
	begin
		if (!wr)
			expAv.push_back(d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge sys_clk);
		while (avs_waitrequest_q)
			@(posedge sys_clk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	end
	endtask
	task automatic hc(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b);
	begin
		i_host.send(1'b0, c);
		i_host.send(1'b1, a);
		i_host.send(1'b1, b);
	end
	endtask
	// RAM phase; pointer expectation walks the window
	task automatic burst(input logic [7:0] c, input int n);
		logic [6:0] x;
		logic [6:0] y;
		logic [7:0] d;
	begin
		x = cs;
		y = rs;
		i_host.send(1'b0, c);
		repeat (n)
		begin
			expAddr.push_back({18'h0, y, x});
			d = 8'($random(seed));
			if (c == 8'h5C)
			begin
				expWr.push_back({24'h0, d});
				i_host.send(1'b1, d);
			end
			else
				i_host.rd();
			if (vert ? y == re : x == ce)
			begin
				x = vert ? ((x == ce) ? cs : x + 7'h01) : cs;
				y = vert ? rs : ((y == re) ? rs : y + 7'h01);
			end
			else
			begin
				x = vert ? x : x + 7'h01;
				y = vert ? y + 7'h01 : y;
			end
		end
		repeat (20) @(posedge sys_clk);
	end
	endtask
	function automatic logic [31:0] lv();
		return {26'h0, colourDepth_q, comSplit_q, comScanReverse_q, colourSwap_q, segRemap_q};
	endfunction
	task automatic finish_test();
	begin
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask
	// Watchdog well past the expected run length
	initial
	begin
		repeat (8000) @(posedge sys_clk);
		n_fail++;
		finish_test();
	end
	// Main sequence
	initial
	begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge sys_clk);
		bus(1'b0, 4'h0, 32'h00007F00);
		bus(1'b0, 4'h4, 32'h00007F00);
		bus(1'b0, 4'h8, 32'h00000060);
		bus(1'b0, 4'h2, 32'h00000000);
		$display("reset values done");
		for (int k = 0; k < 4; k++)
		begin
			cfg = 8'($random(seed)) & 8'hF7;
			cfg[7:6] = 2'(k);
			hc(8'hA0, cfg, 8'h00);
			repeat (8) @(posedge sys_clk);
			chk("remap", {26'h0, cfg[7:6], cfg[5:4], cfg[2:1]}, lv());
			bus(1'b0, 4'h8, {24'h0, cfg});
		end
		$display("remap codes done");
		i_host.send(1'b1, 8'h33);
		i_host.send(1'b0, 8'h15);
		i_host.send(1'b1, 8'h11);
		hc(8'h75, 8'h85, 8'h06);
		hc(8'h15, 8'h02, 8'h84);
		hc(8'hA0, 8'h60, 8'h00);
		repeat (8) @(posedge sys_clk);
		bus(1'b0, 4'h0, 32'h00000402);
		bus(1'b0, 4'h4, 32'h00000605);
		$display("window done");
		i_host.gap = 2;
		burst(8'h5C, 7);
		bus(1'b1, 4'h8, 32'h00000061);
		bus(1'b1, 4'h6, 32'h000000FF);
		bus(1'b0, 4'h8, 32'h00000061);
		vert = 1'b1;
		i_host.gap = 0;
		burst(8'h5C, 5);
		burst(8'h5D, 3);
		bus(1'b0, 4'hC, 32'h04060300);
		hc(8'h15, 8'h00, 8'h7F);
		repeat (8) @(posedge sys_clk);
		bus(1'b0, 4'h0, 32'h00007F00);
		bus(1'b0, 4'hC, 32'h00060300);
		$display("ram access done");
		chk("left over", 32'h0, expAddr.size() + expWr.size() + expRd.size() + expAv.size());
		finish_test();
	end
endmodule
